// ===== hdl/lphs_params.svh
// Constants for the low-power halt sequencer
`ifndef LPHS_PARAMS_SVH
`define LPHS_PARAMS_SVH
`define LPHS_LEVEL_MIN   3'h1
`define LPHS_LEVEL_MAX   3'h7
`define LPHS_OFF_INFO    5'h00
`define LPHS_OFF_ADDR    5'h08
`define LPHS_OFF_DATA    5'h10
`define LPHS_KIND_LSB    0
`define LPHS_KIND_MSB    7
`define LPHS_SIZE_LSB    8
`define LPHS_SIZE_MSB    15
`define LPHS_KIND_NONE   8'h00
`define LPHS_KIND_LOAD   8'h01
`define LPHS_KIND_STORE  8'h02
`define LPHS_SIZE_NONE   8'h00
`define LPHS_SIZE_1      8'h01
`define LPHS_SIZE_2      8'h02
`define LPHS_SIZE_4      8'h04
`define LPHS_SIZE_8      8'h08
`define LPHS_CACHE_BIT   63
`define LPHS_ST_OK       8'h00
`define LPHS_ST_UNIMPL   8'hff
`define LPHS_ST_INVALID  8'hfe
`define LPHS_ST_ERROR    8'hfd
`define LPHS_RESET_ENTRY 64'h0000_0000_ffff_ffb0
`endif

// ===== hdl/lphs_pkg.sv
// Types for the low-power halt sequencer
package lphs_pkg;
  typedef enum logic [2:0]
  {
    lphs_res_caller,
    lphs_res_mgmt_handler,
    lphs_res_mc_handler,
    lphs_res_init_handler,
    lphs_res_reset_entry
  } lphs_resume_t;
endpackage

// ===== hdl/lphs_notify_if.sv
// Notification transaction link between sequencer and platform
`timescale 1ns/1ps
interface lphs_notify_if;
  logic        req;
  logic        write;
  logic [3:0]  size;
  logic [63:0] addr;
  logic        cacheable;
  logic [63:0] wdata;
  logic        ack;
  logic [63:0] rdata;
  logic        halted;
  logic [2:0]  level;
  modport device
  (
    output req, write, size, addr, cacheable, wdata, halted, level,
    input  ack, rdata
  );
  modport platform
  (
    input  req, write, size, addr, cacheable, wdata, halted, level,
    output ack, rdata
  );
endinterface

// ===== hdl/lphs_wake_decode.sv
// Wake source selection and resume target decode
`timescale 1ns/1ps
`include "lphs_params.svh"
module lphs_wake_decode
  import lphs_pkg::*;
(
  input  wire logic         platform_management_interrupt,
  input  wire logic         platform_management_interrupt_masked,
  input  wire logic         mc,
  input  wire logic         init,
  input  wire logic         mc_init_masked,
  input  wire logic         reset_evt,
  input  wire logic         ext_irq,
  input  wire logic [3:0]   ext_irq_class,
  input  wire logic         ext_irq_nmi,
  input  wire logic [3:0]   masked_interrupt_class,
  input  wire logic         mask_all_maskable_interrupts,
  output logic              wake,
  output lphs_resume_t      target
);
  // External interrupt unmasked when mask-all is clear and class above mask class, or NMI
  wire ext_ok = ext_irq & (ext_irq_nmi | (~mask_all_maskable_interrupts
                          & (ext_irq_class > masked_interrupt_class)));
  assign wake = reset_evt | platform_management_interrupt | mc | init | ext_ok;
  // Highest priority source picks the resume point
  always_comb
  begin
    if (reset_evt)
      target = lphs_res_reset_entry;
    else if (mc)
      target = mc_init_masked ? lphs_res_caller : lphs_res_mc_handler;
    else if (init)
      target = mc_init_masked ? lphs_res_caller : lphs_res_init_handler;
    else if (platform_management_interrupt)
      target = platform_management_interrupt_masked ? lphs_res_caller : lphs_res_mgmt_handler;
    else
      target = lphs_res_caller;
  end
endmodule

// ===== hdl/lphs_device.sv
// Low-power halt sequencer, processor end
// Functional notes
// - Level must be 1 to 7
// - Descriptor words: info, address, store data
// - Kind: none, load, store; others reserved
// - Size: none, 1, 2, 4, 8 bytes
// - Address should be size aligned (code does not check alignment and passes any address through)
// - Address bit 63 gives cacheability
// - Store data used only for stores
// - Halt only after platform takes transaction
// - Indicate entered level to platform
// - Wake on management irq, mc, init, reset, interrupt
// - External interrupt gated by priority mask
// - Load result on load, else zero (code returns it only on a wake that resumes at caller, else zero)
// - Interrupt wake resumes at caller
// - Management irq wake: caller if masked, else handler
// - Mc/init wake: caller if masked, else handler
// - Reset wake restarts at reset entry
// - Status codes 0, -1, -2, -3
`timescale 1ns/1ps
`include "lphs_params.svh"
module lphs_device
  import lphs_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rstn,
  lphs_notify_if.device     link,
  input  wire logic         start,
  input  wire logic [63:0]  halt_level,
  input  wire logic [63:0]  desc_info,
  input  wire logic [63:0]  desc_addr,
  input  wire logic [63:0]  desc_data,
  input  wire logic         platform_management_interrupt_in,
  input  wire logic         platform_management_interrupt_masked,
  input  wire logic         mc_in,
  input  wire logic         init_in,
  input  wire logic         mc_init_masked,
  input  wire logic         reset_evt_in,
  input  wire logic         ext_irq_in,
  input  wire logic [3:0]   ext_irq_class,
  input  wire logic         ext_irq_nmi,
  input  wire logic [3:0]   masked_interrupt_class,
  input  wire logic         mask_all_maskable_interrupts,
  output logic              busy,
  output logic              done,
  output logic [7:0]        status,
  output logic [63:0]       load_result,
  output lphs_resume_t      resume_target,
  output logic [63:0]       resume_addr,
  output logic              self_reset
);
  typedef enum {st_idle, st_notify, st_halt} lphs_state_t;
  lphs_state_t state;
  lphs_state_t next_state;

  // Pin-level wake sources are synchronised first
  localparam int NSYNC = 6;
  wire  [NSYNC-1:0] async_in = {platform_management_interrupt_in, mc_in, init_in,
                                reset_evt_in, ext_irq_in, ext_irq_nmi};
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  wire          wake;
  lphs_resume_t target;
  lphs_wake_decode lphs_wake_decode_i
  (
    .platform_management_interrupt        (sync2[5]),
    .platform_management_interrupt_masked (platform_management_interrupt_masked),
    .mc                           (sync2[4]),
    .init                         (sync2[3]),
    .mc_init_masked               (mc_init_masked),
    .reset_evt                    (sync2[2]),
    .ext_irq                      (sync2[1]),
    .ext_irq_class                (ext_irq_class),
    .ext_irq_nmi                  (sync2[0]),
    .masked_interrupt_class       (masked_interrupt_class),
    .mask_all_maskable_interrupts (mask_all_maskable_interrupts),
    .wake                         (wake),
    .target                       (target)
  );

  // Argument checks
  wire [7:0] kind = desc_info[`LPHS_KIND_MSB:`LPHS_KIND_LSB];
  wire [7:0] size = desc_info[`LPHS_SIZE_MSB:`LPHS_SIZE_LSB];
  wire level_ok = (halt_level >= {61'h0, `LPHS_LEVEL_MIN})
                & (halt_level <= {61'h0, `LPHS_LEVEL_MAX});
  wire kind_ok  = (kind == `LPHS_KIND_NONE) | (kind == `LPHS_KIND_LOAD)
                | (kind == `LPHS_KIND_STORE);
  wire size_ok  = (size == `LPHS_SIZE_NONE) | (size == `LPHS_SIZE_1) | (size == `LPHS_SIZE_2)
                | (size == `LPHS_SIZE_4) | (size == `LPHS_SIZE_8);
  wire args_ok  = level_ok & kind_ok & size_ok;
  wire do_xfer  = (kind != `LPHS_KIND_NONE) & (size != `LPHS_SIZE_NONE);
  wire is_load  = (kind == `LPHS_KIND_LOAD);

  // Captured request
  logic        cap_load;
  logic [63:0] cap_rdata;

  // Next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      st_idle:
        if (start && args_ok)
          next_state = do_xfer ? st_notify : st_halt;
      st_notify:
        if (link.ack)
          next_state = st_halt;
      st_halt:
        if (wake)
          next_state = st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state <= st_idle;
    else
      state <= next_state;
  end

  // Notification transaction toward the platform
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      link.req       <= 1'b0;
      link.write     <= 1'b0;
      link.size      <= 4'h0;
      link.addr      <= 64'h0;
      link.cacheable <= 1'b0;
      link.wdata     <= 64'h0;
      cap_load       <= 1'b0;
      cap_rdata      <= 64'h0;
    end
    else if (state == st_idle && start && args_ok)
    begin
      link.req       <= do_xfer;
      link.write     <= (kind == `LPHS_KIND_STORE);
      link.size      <= size[3:0];
      link.addr      <= desc_addr;
      link.cacheable <= desc_addr[`LPHS_CACHE_BIT];
      link.wdata     <= (kind == `LPHS_KIND_STORE) ? desc_data : 64'h0;
      cap_load       <= is_load & do_xfer;
      cap_rdata      <= 64'h0;
    end
    else if (state == st_notify && link.ack)
    begin
      link.req  <= 1'b0;
      cap_rdata <= cap_load ? link.rdata : 64'h0;
    end
  end

  // Entered-level indication
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      link.halted <= 1'b0;
      link.level  <= 3'h0;
    end
    else
    begin
      link.halted <= (next_state == st_halt);
      link.level  <= (state == st_idle && start && args_ok) ? halt_level[2:0] : link.level;
    end
  end

  // Completion reporting
  wire finish_bad  = (state == st_idle) && start && !args_ok;
  wire finish_wake = (state == st_halt) && wake;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy          <= 1'b0;
      done          <= 1'b0;
      status        <= `LPHS_ST_OK;
      load_result   <= 64'h0;
      resume_target <= lphs_res_caller;
      resume_addr   <= 64'h0;
      self_reset    <= 1'b0;
    end
    else
    begin
      busy       <= (next_state != st_idle);
      done       <= finish_bad | finish_wake;
      self_reset <= finish_wake && (target == lphs_res_reset_entry);
      if (finish_bad)
      begin
        status        <= `LPHS_ST_INVALID;
        load_result   <= 64'h0;
        resume_target <= lphs_res_caller;
      end
      else if (finish_wake)
      begin
        status        <= `LPHS_ST_OK;
        load_result   <= (target == lphs_res_caller) ? cap_rdata : 64'h0;
        resume_target <= target;
        resume_addr   <= (target == lphs_res_reset_entry) ? `LPHS_RESET_ENTRY : 64'h0;
      end
    end
  end
endmodule

// ===== hdl/lphs_platform.sv
// Platform end that accepts the halt notification
`timescale 1ns/1ps
`include "lphs_params.svh"
module lphs_platform
#(
  parameter int ACK_DELAY = 2
)
(
  input  wire logic         clock,
  input  wire logic         rstn,
  lphs_notify_if.platform   link,
  input  wire logic [63:0]  load_data,
  output logic              got_req,
  output logic              got_write,
  output logic [63:0]       got_addr,
  output logic [63:0]       got_data,
  output logic [3:0]        got_size,
  output logic              cpu_halted,
  output logic [2:0]        cpu_level
);
  // Acknowledge delay must fit the 8-bit wait counter
  if (ACK_DELAY < 1 || ACK_DELAY > 255)
  begin : g_bad_delay
    $error("ACK_DELAY out of range");
  end
  localparam logic [7:0] ACK_CNT = 8'(ACK_DELAY);
  logic [7:0] cnt;
  wire take = link.req && !link.ack && (cnt == ACK_CNT);
  // Count wait then acknowledge once with read data
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt        <= 8'h00;
      link.ack   <= 1'b0;
      link.rdata <= 64'h0;
      got_req    <= 1'b0;
      got_write  <= 1'b0;
      got_addr   <= 64'h0;
      got_data   <= 64'h0;
      got_size   <= 4'h0;
    end
    else
    begin
      cnt      <= (link.req && !link.ack && cnt != ACK_CNT) ? cnt + 8'h01 : (link.req ? cnt : 8'h00);
      link.ack <= take;
      got_req  <= take;
      if (take)
      begin
        link.rdata <= link.write ? 64'h0 : load_data;
        got_write  <= link.write;
        got_addr   <= link.addr;
        got_data   <= link.wdata;
        got_size   <= link.size;
      end
    end
  end
  // Mirror the halt indication
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_halted <= 1'b0;
      cpu_level  <= 3'h0;
    end
    else
    begin
      cpu_halted <= link.halted;
      cpu_level  <= link.level;
    end
  end
endmodule

// ===== dv/lphs_link_sva.sv
// Checker for the halt notification link
`timescale 1ns/1ps
module lphs_link_sva
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        req,
  input wire logic        write,
  input wire logic [3:0]  size,
  input wire logic [63:0] addr,
  input wire logic        cacheable,
  input wire logic [63:0] wdata,
  input wire logic        ack,
  input wire logic        halted,
  input wire logic [2:0]  level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Request, address, write and store data hold until taken
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(write) && $stable(wdata); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_ack_bound; $rose(req) |-> ##[1:4] ack; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack late");
  property p_halt_after_ack; req && ack |=> !req && halted; endproperty
  a_halt_after_ack: assert property (p_halt_after_ack) else $error("no halt after ack");
  property p_no_early_halt; req |-> !halted; endproperty
  a_no_early_halt: assert property (p_no_early_halt) else $error("halted before ack");
  property p_cache; req |-> cacheable == addr[63]; endproperty
  a_cache: assert property (p_cache) else $error("cacheable differs from address top bit");
  property p_wdata; req && !write |-> wdata == 64'h0; endproperty
  a_wdata: assert property (p_wdata) else $error("store data on a load");
  property p_size; req |-> size inside {4'h1, 4'h2, 4'h4, 4'h8}; endproperty
  a_size: assert property (p_size) else $error("illegal size");
  property p_level; halted |-> level != 3'h0; endproperty
  a_level: assert property (p_level) else $error("halted at level zero");
  property p_level_stable; halted ##1 halted |-> $stable(level); endproperty
  a_level_stable: assert property (p_level_stable) else $error("level moved while halted");
endmodule

// ===== dv/low_power_halt_sequencer_bench.sv
// Self-checking bench for the low-power halt sequencer
`timescale 1ns/1ps
`include "lphs_params.svh"
module low_power_halt_sequencer_bench
  import lphs_pkg::*;
;
  logic         clock = 1'b0;
  logic         rstn = 1'b0;
  logic         start = 1'b0;
  logic [63:0]  lvl = 64'h0, info = 64'h0, addr = 64'h0, data = 64'h0;
  logic [63:0]  load_data = 64'h0123_4567_89ab_cdef;
  logic [5:0]   pins = 6'h00;
  logic         mgmt_m = 1'b0, mci_m = 1'b0, mask_all = 1'b0, saw_req = 1'b0, saw_take = 1'b0;
  logic [3:0]   cls = 4'h0, mask_cls = 4'h0;
  logic         busy, done, self_reset, got_req, got_write, cpu_halted;
  logic [7:0]   status;
  logic [63:0]  load_result, resume_addr, got_addr, got_data;
  lphs_resume_t resume_target;
  logic [3:0]   got_size;
  logic [2:0]   cpu_level;
  int           bad_count = 0;
  int           compares = 0;
  // Clock
  always #5 clock = ~clock;
  lphs_notify_if lphs_notify_if_i ();
  lphs_device lphs_device_i (.clock(clock), .rstn(rstn), .link(lphs_notify_if_i), .start(start), .halt_level(lvl),
    .desc_info(info), .desc_addr(addr), .desc_data(data), .platform_management_interrupt_in(pins[5]),
    .platform_management_interrupt_masked(mgmt_m), .mc_in(pins[4]),
    .init_in(pins[3]), .mc_init_masked(mci_m), .reset_evt_in(pins[2]), .ext_irq_in(pins[1]), .ext_irq_class(cls),
    .ext_irq_nmi(pins[0]), .masked_interrupt_class(mask_cls), .mask_all_maskable_interrupts(mask_all), .busy(busy),
    .done(done), .status(status), .load_result(load_result), .resume_target(resume_target),
    .resume_addr(resume_addr), .self_reset(self_reset));
  lphs_platform #(.ACK_DELAY(2)) lphs_platform_i (.clock(clock), .rstn(rstn), .link(lphs_notify_if_i),
    .load_data(load_data), .got_req(got_req), .got_write(got_write), .got_addr(got_addr), .got_data(got_data),
    .got_size(got_size), .cpu_halted(cpu_halted), .cpu_level(cpu_level));
  lphs_link_sva lphs_link_sva_i (.clock(clock), .rstn(rstn), .req(lphs_notify_if_i.req),
    .write(lphs_notify_if_i.write), .size(lphs_notify_if_i.size), .addr(lphs_notify_if_i.addr),
    .cacheable(lphs_notify_if_i.cacheable), .wdata(lphs_notify_if_i.wdata), .ack(lphs_notify_if_i.ack),
    .halted(lphs_notify_if_i.halted), .level(lphs_notify_if_i.level));
  // Request and acceptance watcher, cleared while start is driven
  always @(posedge clock)
  begin
    saw_req  <= start ? 1'b0 : (saw_req | lphs_notify_if_i.req);
    saw_take <= start ? 1'b0 : (saw_take | got_req);
  end
  // Comparison and verdict
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_done(input int n);
    for (int i = 0; i < n && done !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic issue(input logic [63:0] l, i, a, d);
    @(posedge clock);
    start <= 1'b1;
    lvl <= l;
    info <= i;
    addr <= a;
    data <= d;
    @(posedge clock);
    start <= 1'b0;
    #1;
  endtask
  // Reserved argument: invalid status, no transaction, no halt
  task automatic bad_req(input logic [63:0] l, i);
    issue(l, i, 64'h40, 64'h5);
    wait_done(5);
    chk("done", 1, done);
    chk("busy", 0, busy);
    chk("status", `LPHS_ST_INVALID, status);
    chk("saw_req", 0, saw_req);
    chk("halted", 0, cpu_halted);
  endtask
  // Full halt: optional transaction, blocked wake, real wake, resume
  task automatic halt_cycle(input logic [63:0] l, i, a, d, input logic [5:0] pre, wk,
                            input lphs_resume_t tgt, input logic [63:0] res);
    issue(l, i, a, d);
    for (int n = 0; n < 20 && cpu_halted !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk("halted", 1, cpu_halted);
    chk("busy", 1, busy);
    chk("level", l[2:0], cpu_level);
    chk("got_req", i[15:0] != 16'h0, saw_req);
    chk("got_take", i[15:0] != 16'h0, saw_take);
    if (i[15:0] != 16'h0)
    begin
      chk("got_addr", a, got_addr);
      chk("got_size", i[11:8], got_size);
      chk("got_write", i[7:0] == `LPHS_KIND_STORE, got_write);
      if (i[7:0] == `LPHS_KIND_STORE) chk("got_data", d, got_data);
    end
    @(posedge clock);
    pins <= pre;
    if (pre != 6'h0)
    begin
      repeat (6)
      begin
        @(posedge clock);
        #1;
        chk("done", 0, done);
      end
    end
    @(posedge clock);
    pins <= wk;
    #1;
    wait_done(12);
    chk("done", 1, done);
    chk("busy", 0, busy);
    chk("status", `LPHS_ST_OK, status);
    chk("target", tgt, resume_target);
    chk("result", res, load_result);
    chk("self_reset", tgt == lphs_res_reset_entry, self_reset);
    chk("resume_addr", tgt == lphs_res_reset_entry ? `LPHS_RESET_ENTRY : 64'h0, resume_addr);
    @(posedge clock);
    pins <= 6'h00;
  endtask
  task automatic t_reserved();
    bad_req(64'h0, 64'h0801);
    bad_req(64'h8, 64'h0801);
    bad_req(64'h1, 64'h0803);
    bad_req(64'h1, 64'h0301);
  endtask
  task automatic t_load_nmi();
    halt_cycle(64'h7, 64'h0801, 64'h8000_0000_0000_1000, 64'h5a, 6'h0, 6'h03, lphs_res_caller, load_data);
  endtask
  task automatic t_store_mgmt();
    mgmt_m <= 1'b0;
    halt_cycle(64'h2, 64'h0402, 64'h2000, 64'h1122_3344_5566_7788, 6'h0, 6'h20, lphs_res_mgmt_handler, 0);
  endtask
  task automatic t_masked_irq();
    {mask_all, cls, mask_cls, mgmt_m} <= {1'b0, 4'h2, 4'h5, 1'b1};
    halt_cycle(64'h1, 64'h0201, 64'h3002, 64'h0, 6'h02, 6'h20, lphs_res_caller, load_data);
  endtask
  task automatic t_mc_init();
    for (int m = 0; m < 2; m++)
    begin
      mci_m <= m[0];
      halt_cycle(64'h3, 64'h0101, 64'h10, 64'h0, 6'h0, 6'h10, m ? lphs_res_caller : lphs_res_mc_handler,
                 m ? load_data : 64'h0);
      halt_cycle(64'h4, 64'h0, 64'h0, 64'h0, 6'h0, 6'h08, m ? lphs_res_caller : lphs_res_init_handler, 0);
    end
  endtask
  task automatic t_reset_wake();
    halt_cycle(64'h3, 64'h0, 64'h0, 64'h0, 6'h0, 6'h04, lphs_res_reset_entry, 0);
  endtask
  // Watchdog
  initial
  begin
    #100000;
    bad_count++;
    print_verdict();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_reserved();
    t_load_nmi();
    t_store_mgmt();
    t_masked_irq();
    t_mc_init();
    t_reset_wake();
    print_verdict();
  end
endmodule
